// ===== design/setting_group_selector_map.vh
// Purpose: Register offsets, field positions, reset values and event bits of the selector.
// Assumes: Byte addresses on a 32-bit Avalon-MM bus, one register per aligned word.
// Notes:   Group codes are zero based: code 0 is group_one, code 7 is group_eight.
`ifndef SETTING_GROUP_SELECTOR_MAP_VH
`define SETTING_GROUP_SELECTOR_MAP_VH

// ==========================================================================
// Register offsets.
`define SGS_OFF_ACTIVE 6'h00
`define SGS_OFF_CONTROL 6'h04
`define SGS_OFF_FORCE 6'h08
`define SGS_OFF_REMOTE 6'h0c
`define SGS_OFF_STATUS 6'h10
`define SGS_OFF_MASK 6'h14
`define SGS_OFF_LEVELS 6'h18

// ==========================================================================
// Control register fields.
`define SGS_CTL_FORCE_EN 0
`define SGS_CTL_XFMR_FOLLOW 1
`define SGS_CTL_USED_LO 4
`define SGS_CTL_USED_HI 6

// ==========================================================================
// Reset values.
`define SGS_RST_ACTIVE 3'h0
`define SGS_RST_USED 3'h0
`define SGS_RST_SELECT 4'h0
`define SGS_RST_MASK 12'h000

// ==========================================================================
// Event bits of the status and mask registers.
`define SGS_EV_COUNT 12
`define SGS_EV_ENABLED 0
`define SGS_EV_DISABLED 1
`define SGS_EV_REQ_ON 2
`define SGS_EV_REQ_OFF 3
`define SGS_EV_REMOTE 4
`define SGS_EV_LOCAL 5
`define SGS_EV_FORCE_ON 6
`define SGS_EV_FORCE_OFF 7
`define SGS_EV_FAIL_CFG 8
`define SGS_EV_FAIL_PRIO 9
`define SGS_EV_ACTIVE 10
`define SGS_EV_FAIL_FORCE 11

`endif

// ===== design/request_edge.v
// Purpose: Rise and fall detection on each group request input.
// Assumes: Inputs are synchronous to ref_clk.
// Notes:   One pulse per edge; a held level gives no further pulses.
`timescale 1ns/10ps

module request_edge #(
    parameter WIDTH = 8
) (
    input wire ref_clk,
    input wire reset_n,
    input wire [WIDTH-1:0] req_level,
    output wire [WIDTH-1:0] req_rise,
    output wire [WIDTH-1:0] req_fall
);

    // ======================================================================
    // Per-input history and edge pulses.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_edge
            reg prev_ff;
            // Remember the previous sample of the input.
            always @(posedge ref_clk) begin
                if (!reset_n) begin
                    prev_ff <= 1'b0;
                end else begin
                    prev_ff <= req_level[i];
                end
            end
            // A pulse request is one rising edge, seen exactly once.
            assign req_rise[i] = req_level[i] & ~prev_ff;
            assign req_fall[i] = ~req_level[i] & prev_ff;
        end
    endgenerate

endmodule

// ===== design/setting_group_selector.v
// Purpose: Selects which of eight setting groups is active, with forcing and events.
// Assumes: Avalon-MM slave with waitrequest; request inputs synchronous to ref_clk.
// Notes:   Group code 0 is group_one, the highest priority.
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "setting_group_selector_map.vh"

module setting_group_selector (
    input wire ref_clk,
    input wire reset_n,
    input wire [5:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    output reg [31:0] readdata,
    output wire waitrequest,
    input wire [7:0] group_req,
    input wire local_force_valid,
    input wire [3:0] local_force_group,
    output wire [2:0] active_group,
    output wire [7:0] active_onehot,
    output wire [2:0] xfmr_group,
    output wire [7:0] group_enabled,
    output wire [7:0] default_load,
    output wire irq
);

    // ======================================================================
    // Declarations.
    reg ack_ff;
    reg [2:0] active_ff;
    reg [2:0] xfmr_ff;
    reg force_en_ff;
    reg xfmr_follow_ff;
    reg [2:0] used_ff;
    reg [3:0] force_sel_ff;
    reg [3:0] remote_sel_ff;
    reg [11:0] status_ff;
    reg [11:0] mask_ff;
    reg release_ff;
    reg [7:0] load_ff;
    reg [7:0] nxt_load;
    reg [31:0] nxt_rdata;
    reg [7:0] enabled;
    reg [7:0] force_oh;
    reg [7:0] remote_oh;
    reg [7:0] cand;
    reg [7:0] cand_ok;
    reg [3:0] win;
    reg [3:0] hold;
    reg blocked;
    reg take;
    reg [11:0] ev;
    reg [7:0] onehot_ff;
    reg [7:0] enabled_ff;
    reg [7:0] nxt_enabled;
    integer int_i;
    wire [7:0] req_rise;
    wire [7:0] req_fall;
    wire access;
    wire wr_go;
    wire rd_go;
    wire bus_force;
    wire any_force;
    wire [3:0] force_code;
    wire [2:0] new_used;
    wire new_force_en;
    wire [5:0] word_addr;
    wire ctl_wr;
    wire remote_wr;
    wire status_rd;

    // ======================================================================
    // Lowest set bit, i.e. the highest priority group; bit 3 flags a hit.
    function [3:0] first_set;
        input [7:0] v;
        integer k;
        begin
            first_set = 4'h0;
            for (k = 7; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    first_set = {1'b1, k[2:0]};
                end
            end
        end
    endfunction

    // Turns a selector value (0 none, 1..8 group) into a one-hot vector.
    function [7:0] sel_onehot;
        input [3:0] sel;
        begin
            if (sel == 4'h0 || sel > 4'h8) begin
                sel_onehot = 8'h00;
            end else begin
                sel_onehot = 8'h01 << (sel - 4'h1);
            end
        end
    endfunction

    // ======================================================================
    // Edge detection of the request inputs.
    request_edge #(
        .WIDTH(8)
    ) u_edge (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .req_level(group_req),
        .req_rise(req_rise),
        .req_fall(req_fall)
    );

    // ======================================================================
    // Bus handshake: every access waits one cycle, then completes.
    assign access = read | write;
    assign waitrequest = access & ~ack_ff;
    assign wr_go = write & ack_ff;
    assign rd_go = read & ack_ff;

    // Completion flag that releases waitrequest in the second cycle.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= access & ~ack_ff;
        end
    end

    // Read data is assembled in the waiting cycle and stands at completion.
    always @* begin
        nxt_rdata = 32'h0000_0000;
        case ({address[5:2], 2'b00})
            `SGS_OFF_ACTIVE: begin
                nxt_rdata = {21'h0, xfmr_ff, 5'h0, active_ff};
            end
            `SGS_OFF_CONTROL: begin
                nxt_rdata = {25'h0, used_ff, 2'h0, xfmr_follow_ff, force_en_ff};
            end
            `SGS_OFF_FORCE: begin
                nxt_rdata = {28'h0, force_sel_ff};
            end
            `SGS_OFF_REMOTE: begin
                nxt_rdata = {28'h0, remote_sel_ff};
            end
            `SGS_OFF_STATUS: begin
                nxt_rdata = {20'h0, status_ff};
            end
            `SGS_OFF_MASK: begin
                nxt_rdata = {20'h0, mask_ff};
            end
            `SGS_OFF_LEVELS: begin
                nxt_rdata = {16'h0, enabled, group_req};
            end
            default: begin
                nxt_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data register, loaded while the access waits.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            readdata <= 32'h0000_0000;
        end else if (read & ~ack_ff) begin
            readdata <= nxt_rdata;
        end
    end

    // ======================================================================
    // Word address and the strobes of completed accesses; every control, force
    // and remote field lives in byte lane 0, so lane 0 qualifies the strobes.
    assign word_addr = {address[5:2], 2'b00};
    assign ctl_wr = wr_go && byteenable[0] && (word_addr == `SGS_OFF_CONTROL);
    assign remote_wr = wr_go && byteenable[0] && (word_addr == `SGS_OFF_REMOTE);
    // A read of the status register clears it at the completing edge.
    assign status_rd = rd_go && (word_addr == `SGS_OFF_STATUS);

    // ======================================================================
    // Write decode of control and selector values.
    assign bus_force = wr_go && byteenable[0] && (word_addr == `SGS_OFF_FORCE);
    // The values the control fields take at the next edge.
    assign new_used = ctl_wr ? writedata[`SGS_CTL_USED_HI:`SGS_CTL_USED_LO] : used_ff;
    assign new_force_en = ctl_wr ? writedata[`SGS_CTL_FORCE_EN] : force_en_ff;
    // Bus forcing takes precedence over a panel request in the same cycle.
    assign any_force = bus_force | local_force_valid;
    assign force_code = bus_force ? writedata[3:0] : local_force_group;

    // Configuration registers; force enable only changes on a software write.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            force_en_ff <= 1'b0;
            xfmr_follow_ff <= 1'b0;
            used_ff <= `SGS_RST_USED;
            force_sel_ff <= `SGS_RST_SELECT;
            remote_sel_ff <= `SGS_RST_SELECT;
            mask_ff <= `SGS_RST_MASK;
        end else begin
            force_en_ff <= new_force_en;
            used_ff <= new_used;
            if (ctl_wr) begin
                xfmr_follow_ff <= writedata[`SGS_CTL_XFMR_FOLLOW];
            end
            if (any_force) begin
                force_sel_ff <= force_code;
            end
            if (remote_wr) begin
                remote_sel_ff <= writedata[3:0];
            end
            if (wr_go && (word_addr == `SGS_OFF_MASK)) begin
                if (byteenable[0]) begin
                    mask_ff[7:0] <= writedata[7:0];
                end
                if (byteenable[1]) begin
                    mask_ff[11:8] <= writedata[11:8];
                end
            end
        end
    end

    // ======================================================================
    // Group arbitration.
    always @* begin
        enabled = 8'h00;
        nxt_enabled = 8'h00;
        nxt_load = 8'h00;
        for (int_i = 0; int_i < 8; int_i = int_i + 1) begin
            enabled[int_i] = (int_i[2:0] <= used_ff);
            // Next edge's enable run, so the registered copy never lags.
            nxt_enabled[int_i] = (int_i[2:0] <= new_used);
            // Groups newly brought into use get their defaults loaded.
            nxt_load[int_i] = (int_i[2:0] <= new_used) && (int_i[2:0] > used_ff);
        end
        force_oh = sel_onehot(force_code);
        // A remote write is one request, seen only in its completing cycle.
        remote_oh = remote_wr ? sel_onehot(writedata[3:0]) : 8'h00;
        if (force_en_ff) begin
            // Only the user's forced selection counts while forcing is on.
            cand = any_force ? force_oh : 8'h00;
        end else begin
            // Edges are pulse requests; held levels re-enter at force release.
            cand = req_rise | remote_oh | (release_ff ? group_req : 8'h00);
        end
        cand_ok = cand & enabled;
        win = first_set(cand_ok);
        hold = first_set(group_req & enabled);
        // Outside forcing, a held higher-priority level refuses any lower-priority request.
        blocked = !force_en_ff && hold[3] && win[3] && (hold[2:0] < win[2:0]);
        take = win[3] && !blocked;
    end

    // Active group: changes only on an accepted request, otherwise held.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            active_ff <= `SGS_RST_ACTIVE;
            release_ff <= 1'b0;
            load_ff <= 8'h00;
        end else begin
            if (take) begin
                active_ff <= win[2:0];
            end
            release_ff <= force_en_ff & ~new_force_en;
            load_ff <= nxt_load;
        end
    end

    // Registered copies of the decoded outputs, so that the pins come
    // straight from flip-flops and move at the same edge as their source.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            onehot_ff <= 8'h01;
            enabled_ff <= 8'h01;
        end else begin
            if (take) begin
                onehot_ff <= 8'h01 << win[2:0];
            end
            enabled_ff <= nxt_enabled;
        end
    end

    // Transformer parameter group follows only while following is enabled.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            xfmr_ff <= `SGS_RST_ACTIVE;
        end else if (xfmr_follow_ff) begin
            xfmr_ff <= take ? win[2:0] : active_ff;
        end
    end

    // ======================================================================
    // Events, sticky status and interrupt.
    always @* begin
        ev = 12'h000;
        ev[`SGS_EV_ENABLED] = (new_used > used_ff);
        ev[`SGS_EV_DISABLED] = (new_used < used_ff);
        ev[`SGS_EV_REQ_ON] = |req_rise;
        ev[`SGS_EV_REQ_OFF] = |req_fall;
        ev[`SGS_EV_REMOTE] = !force_en_ff && (|(remote_oh & enabled)) && take
            && !req_rise[win[2:0]];
        ev[`SGS_EV_LOCAL] = force_en_ff && local_force_valid && !bus_force && take;
        ev[`SGS_EV_FORCE_ON] = new_force_en & ~force_en_ff;
        ev[`SGS_EV_FORCE_OFF] = force_en_ff & ~new_force_en;
        ev[`SGS_EV_FAIL_CFG] = |(cand & ~enabled);
        ev[`SGS_EV_FAIL_PRIO] = blocked;
        ev[`SGS_EV_ACTIVE] = take && (win[2:0] != active_ff);
        ev[`SGS_EV_FAIL_FORCE] = any_force && !force_en_ff;
    end

    // Status bits stick until read; a new event wins over the clearing read.
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            status_ff <= 12'h000;
        end else if (status_rd) begin
            status_ff <= ev;
        end else begin
            status_ff <= status_ff | ev;
        end
    end

    // ======================================================================
    // Outputs.
    assign irq = |(status_ff & mask_ff);
    assign active_group = active_ff;
    assign active_onehot = onehot_ff;
    assign xfmr_group = xfmr_ff;
    assign group_enabled = enabled_ff;
    assign default_load = load_ff;

endmodule

// ===== verification/setting_group_selector_properties.sv
// Purpose: Port-level properties of the setting group selector.
// Assumes: Attached by bind; only the top ports are visible.
// Notes:   Force and follow bits are mirrored from completed control writes.
`timescale 1ns/10ps

module setting_group_selector_properties (
    input wire ref_clk,
    input wire reset_n,
    input wire [5:0] address,
    input wire write,
    input wire [31:0] writedata,
    input wire [3:0] byteenable,
    input wire waitrequest,
    input wire [7:0] group_req,
    input wire local_force_valid,
    input wire [2:0] active_group,
    input wire [7:0] active_onehot,
    input wire [2:0] xfmr_group,
    input wire [7:0] group_enabled,
    input wire [7:0] default_load
);
    reg force_ff;
    reg follow_ff;
    reg [1:0] free_cnt_ff;
    wire ctl_wr;

    // ======================================================================
    // Helper state: control bits and cycles since forcing ended, so that
    // automatic requests are only judged once the release has settled.
    assign ctl_wr = write && !waitrequest && (address[5:2] == 4'h1) && byteenable[0];
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            force_ff <= 1'b0;
            follow_ff <= 1'b0;
        end else if (ctl_wr) begin
            force_ff <= writedata[0];
            follow_ff <= writedata[1];
        end
    end
    // Saturating count of free-running cycles.
    always @(posedge ref_clk) begin
        if (!reset_n || force_ff) begin
            free_cnt_ff <= 2'h0;
        end else if (free_cnt_ff != 2'h3) begin
            free_cnt_ff <= free_cnt_ff + 2'h1;
        end
    end

    // ======================================================================
    // Properties.
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    onehot_match_a: assert property (active_onehot == (8'h01 << active_group))
        else $error("active one-hot does not match active code");
    used_thermo_a: assert property (group_enabled[0] &&
        ((group_enabled & (group_enabled + 8'h01)) == 8'h00))
        else $error("enabled groups are not a run from group one");
    new_load_a: assert property ((group_enabled & ~$past(group_enabled)) != 8'h00
        |-> ##[0:1] default_load != 8'h00)
        else $error("newly enabled group got no default load");
    pulse_take_a: assert property (free_cnt_ff == 2'h3 && !write &&
        $past(group_req) == 8'h00 && group_req != 8'h00 &&
        (group_req & (group_req - 8'h01)) == 8'h00 && (group_req & ~group_enabled) == 8'h00
        |=> active_onehot == $past(group_req))
        else $error("single request edge not taken next cycle");
    hold_one_a: assert property (free_cnt_ff == 2'h3 && group_req[0] && $past(group_req[0])
        |-> active_group == 3'h0)
        else $error("held group one did not keep control");
    force_hold_a: assert property (force_ff && !write && !local_force_valid
        |=> $stable(active_group))
        else $error("active group moved while forcing without a forced request");
    quiet_keep_a: assert property (!write && !local_force_valid && group_req == 8'h00
        && $past(group_req) == 8'h00 |=> $stable(active_group))
        else $error("active group moved with no request");
    xfmr_follow_a: assert property ((follow_ff && $stable(active_group)) [*3]
        |-> xfmr_group == active_group)
        else $error("transformer group does not follow active group");

    cover property (free_cnt_ff == 2'h3 && $rose(group_req[3]));
    cover property (force_ff && local_force_valid);
    cover property ($rose(follow_ff));
endmodule

// ===== verification/req_source.sv
// Purpose: Model of the request sources: logic inputs, digital inputs, panel.
// Assumes: Called from the bench; drives right after rising edges.
// Notes:   Pulses are laid over held levels; panel group scrambles when idle.
`timescale 1ns/10ps

module req_source (
    input wire ref_clk,
    output logic [7:0] group_req,
    output logic local_force_valid,
    output logic [3:0] local_force_group
);
    // ======================================================================
    // Nothing is requested at time zero.
    initial begin
        group_req = 8'h00;
        local_force_valid = 1'b0;
        local_force_group = 4'h0;
    end
    // Sustained request levels, one line per group.
    task hold(input [7:0] v);
        begin
            @(posedge ref_clk);
            group_req <= v;
        end
    endtask
    // One-cycle pulse on top of any held levels.
    task pulse(input [7:0] v);
        begin
            @(posedge ref_clk);
            group_req <= group_req | v;
            @(posedge ref_clk);
            group_req <= group_req & ~v;
        end
    endtask
    // Panel selection; the group lines hold no meaning once unqualified.
    task panel(input [3:0] g);
        begin
            @(posedge ref_clk);
            local_force_group <= g;
            local_force_valid <= 1'b1;
            @(posedge ref_clk);
            local_force_valid <= 1'b0;
            local_force_group <= ~g;
        end
    endtask
endmodule

// ===== verification/setting_group_selector_tb.sv
// Purpose: Self-checking bench for the setting group selector.
// Assumes: Avalon-MM master tasks; request sources come from req_source.
// Notes:   Output checks are made mid-cycle so design updates have landed; bus access results are checked at a rising edge.
`timescale 1ns/10ps
`include "setting_group_selector_map.vh"

module setting_group_selector_tb;
    logic ref_clk;
    logic reset_n;
    logic [5:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] q;
    wire [31:0] readdata;
    wire waitrequest;
    wire [7:0] group_req;
    wire local_force_valid;
    wire [3:0] local_force_group;
    wire [2:0] active_group;
    wire [7:0] active_onehot;
    wire [2:0] xfmr_group;
    wire [7:0] group_enabled;
    wire [7:0] default_load;
    wire irq;
    integer n_mismatch;
    integer n_checks;
    integer i;

    setting_group_selector dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .group_req(group_req),
        .local_force_valid(local_force_valid), .local_force_group(local_force_group),
        .active_group(active_group), .active_onehot(active_onehot), .xfmr_group(xfmr_group),
        .group_enabled(group_enabled), .default_load(default_load), .irq(irq));
    req_source src_u (.ref_clk(ref_clk), .group_req(group_req),
        .local_force_valid(local_force_valid), .local_force_group(local_force_group));

    // ======================================================================
    // Clock and watchdog.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch = n_mismatch + 1;
        close_out;
    end

    // ======================================================================
    // Tasks.
    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            n_checks = n_checks + 1;
            if (g !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("ERROR %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    // One bus access, held until waitrequest is seen low at a rising edge.
    task xfer(input w, input [5:0] a, input [31:0] d);
        integer n;
        begin
            n = 0;
            @(posedge ref_clk);
            address <= a;
            writedata <= d;
            write <= w;
            read <= !w;
            @(posedge ref_clk);
            while (waitrequest !== 1'b0 && n < 20) begin
                n = n + 1;
                @(posedge ref_clk);
            end
            chk("waitrequest", 32'h0, {31'h0, waitrequest});
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask
    task act(input [2:0] e);
        begin
            repeat (3) @(negedge ref_clk);
            chk("active_group", {29'h0, e}, {29'h0, active_group});
        end
    endtask
    task ev(input integer b);
        begin
            xfer(1'b0, `SGS_OFF_STATUS, 32'h0);
            chk("status bit", 32'h1, (q >> b) & 32'h1);
        end
    endtask
    task close_out;
        begin
            $display("checks %0d mismatches %0d", n_checks, n_mismatch);
            if (n_mismatch == 0 && n_checks > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask

    // ======================================================================
    // Main sequence.
    initial begin
        reset_n = 1'b0;
        address = 6'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'hf;
        q = 32'h0;
        n_mismatch = 0;
        n_checks = 0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk("group_enabled", 32'h1, {24'h0, group_enabled});
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, `SGS_OFF_ACTIVE, 32'h7);
        for (i = 0; i < 4; i = i + 1) begin
            xfer(1'b0, {i[3:0], 2'b00}, 32'h0);
            chk("reset value", 32'h0, q);
        end
        xfer(1'b0, 6'h1c, 32'h0);
        chk("unmapped", 32'h0, q);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h70);
        @(negedge ref_clk);
        chk("group_enabled", 32'hff, {24'h0, group_enabled});
        for (i = 7; i >= 0; i = i - 1) begin
            src_u.pulse(8'h01 << i);
            act(i[2:0]);
        end
        src_u.hold(8'h28);
        act(3'h3);
        src_u.pulse(8'h40);
        act(3'h3);
        ev(`SGS_EV_FAIL_PRIO);
        src_u.pulse(8'h02);
        act(3'h1);
        src_u.hold(8'h01);
        act(3'h0);
        src_u.pulse(8'h02);
        act(3'h0);
        src_u.hold(8'h02);
        act(3'h1);
        xfer(1'b1, `SGS_OFF_REMOTE, 32'h5);
        act(3'h1);
        src_u.hold(8'h00);
        xfer(1'b1, `SGS_OFF_REMOTE, 32'h5);
        act(3'h4);
        xfer(1'b1, `SGS_OFF_MASK, 32'h400);
        xfer(1'b0, `SGS_OFF_STATUS, 32'h0);
        src_u.pulse(8'h01);
        act(3'h0);
        chk("irq", 32'h1, {31'h0, irq});
        ev(`SGS_EV_ACTIVE);
        @(negedge ref_clk);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, `SGS_OFF_MASK, 32'h0);
        src_u.pulse(8'h02);
        act(3'h1);
        chk("irq", 32'h0, {31'h0, irq});
        xfer(1'b1, `SGS_OFF_FORCE, 32'h3);
        act(3'h1);
        ev(`SGS_EV_FAIL_FORCE);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h71);
        xfer(1'b1, `SGS_OFF_FORCE, 32'h6);
        act(3'h5);
        src_u.pulse(8'h01);
        act(3'h5);
        src_u.panel(4'h8);
        act(3'h7);
        src_u.hold(8'h04);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h70);
        act(3'h2);
        src_u.hold(8'h00);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h71);
        xfer(1'b1, `SGS_OFF_FORCE, 32'h5);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h70);
        act(3'h4);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h71);
        xfer(1'b1, `SGS_OFF_FORCE, 32'h2);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h33);
        xfer(1'b1, `SGS_OFF_FORCE, 32'h7);
        act(3'h1);
        chk("group_enabled", 32'h0f, {24'h0, group_enabled});
        chk("xfmr_group", 32'h1, {29'h0, xfmr_group});
        ev(`SGS_EV_FAIL_CFG);
        xfer(1'b0, `SGS_OFF_ACTIVE, 32'h0);
        chk("active register", 32'h101, q);
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h30);
        src_u.pulse(8'h20);
        act(3'h1);
        @(posedge ref_clk);
        byteenable <= 4'h2;
        xfer(1'b1, `SGS_OFF_CONTROL, 32'h71);
        xfer(1'b1, `SGS_OFF_MASK, 32'hf00);
        byteenable <= 4'hf;
        xfer(1'b0, `SGS_OFF_CONTROL, 32'h0);
        chk("control lanes", 32'h30, q);
        xfer(1'b0, `SGS_OFF_MASK, 32'h0);
        chk("mask lanes", 32'hf00, q);
        close_out;
    end
endmodule

bind setting_group_selector setting_group_selector_properties chk_u (.ref_clk(ref_clk),
    .reset_n(reset_n), .address(address), .write(write), .writedata(writedata),
    .byteenable(byteenable), .waitrequest(waitrequest), .group_req(group_req),
    .local_force_valid(local_force_valid), .active_group(active_group),
    .active_onehot(active_onehot), .xfmr_group(xfmr_group), .group_enabled(group_enabled),
    .default_load(default_load));
